//--- core/dcu_compare_unit.v
// The AHB-Lite interface to the registers and the register offsets were decided locally.
`include "dcu_defines.vh"

module dcu_compare_unit #(
    parameter WMEM_AW = 6,
    parameter BMEM_AW = 8
) (
    input  wire        mclk,
    input  wire        rst,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg         hreadyout,
    output reg         hresp,
    output reg  [31:0] hrdata,
    output reg         result_bit,
    output reg         greater_flag,
    output reg         equal_flag,
    output reg         less_flag,
    output reg         busy
);

    localparam WMEM_N = 1 << WMEM_AW;
    localparam BMEM_N = 1 << BMEM_AW;
    localparam BWORDS = BMEM_N / `DCU_BITS_PER_WORD;
    localparam ST_IDLE = 1'b0;
    localparam ST_RUN  = 1'b1;

    // ************************************************************
    // Relation evaluation
    // ************************************************************

    // Sign bit flipped turns a signed compare into an unsigned one
    function [15:0] sign_adj;
        input        sgn;
        input [15:0] v;
        begin
            sign_adj = sgn ? {~v[15], v[14:0]} : v;
        end
    endfunction

    // Relation select; one comparator serves both data types
    function rel_eval;
        input [2:0]  f_op;
        input        f_int;
        input [15:0] a;
        input [15:0] b;
        reg   [15:0] ua;
        reg   [15:0] ub;
        begin
            ua = sign_adj(f_int, a);
            ub = sign_adj(f_int, b);
            case (f_op)
                `DCU_OP_EQ: rel_eval = (ua == ub);
                `DCU_OP_NE: rel_eval = (ua != ub);
                `DCU_OP_LT: rel_eval = (ua <  ub);
                `DCU_OP_GT: rel_eval = (ua >  ub);
                `DCU_OP_LE: rel_eval = (ua <= ub);
                `DCU_OP_GE: rel_eval = (ua >= ub);
                default:    rel_eval = 1'b0;
            endcase
        end
    endfunction

    // ************************************************************
    // Operand memories
    // ************************************************************

    // Word area: timers, counters (current value) and data registers
    reg [15:0]        wmem_r [0:WMEM_N-1];
    // Bit area: inputs, outputs, relays, shift register bits
    reg [BMEM_N-1:0]  bmem_r;

    // Gather sixteen bits from any bit address, wrapping at the top
    function [15:0] gather;
        input [BMEM_N-1:0]  mem;
        input [BMEM_AW-1:0] base;
        integer             j;
        reg [BMEM_AW-1:0]   p;
        begin
            gather = 16'h0000;
            for (j = 0; j < `DCU_BITS_PER_WORD; j = j + 1)
            begin
                p = base + j[BMEM_AW-1:0];
                gather[j] = mem[p];
            end
        end
    endfunction

    // ************************************************************
    // Control registers
    // ************************************************************

    reg [`DCU_CTRL_W-1:0] ctrl_r;
    reg [6:0]             rep_r;
    reg [15:0]            src1_r;
    reg [15:0]            src2_r;
    reg [15:0]            dest_r;
    reg                   state_r;
    reg [6:0]             idx_r;
    reg                   acc_r;

    wire [2:0] op      = ctrl_r[`DCU_CTRL_OP_LSB +: 3];
    wire       is_int  = ctrl_r[`DCU_CTRL_INT];
    wire       s1_rep  = ctrl_r[`DCU_CTRL_S1_REP];
    wire       s2_rep  = ctrl_r[`DCU_CTRL_S2_REP];
    wire       d_rep   = ctrl_r[`DCU_CTRL_D_REP];
    wire [1:0] s1_kind = ctrl_r[`DCU_CTRL_S1_LSB +: 2];
    wire [1:0] s2_kind = ctrl_r[`DCU_CTRL_S2_LSB +: 2];

    // ************************************************************
    // Bus address phase capture
    // ************************************************************

    reg        wr_pend_r;
    reg [11:0] wr_addr_r;
    wire       take = hsel && htrans[1] && hready;

    // Read data is prepared in the address phase so hrdata is a flop
    reg [31:0] rd_nxt;
    always @*
    begin
        rd_nxt = 32'h0000_0000;
        if (haddr[11:8] == `DCU_WIN_WORD)
            rd_nxt = {16'h0000, wmem_r[haddr[WMEM_AW+1:2]]};
        else if (haddr[11:8] == `DCU_WIN_BIT)
        begin
            if (haddr[7:2] < BWORDS)
                rd_nxt = {16'h0000, bmem_r[haddr[7:2]*`DCU_BITS_PER_WORD +: 16]};
        end
        else
        begin
            case (haddr[11:0])
                `DCU_OFS_CTRL:   rd_nxt = {21'h000000, ctrl_r};
                `DCU_OFS_REPEAT: rd_nxt = {25'h0000000, rep_r};
                `DCU_OFS_SRC1:   rd_nxt = {16'h0000, src1_r};
                `DCU_OFS_SRC2:   rd_nxt = {16'h0000, src2_r};
                `DCU_OFS_DEST:   rd_nxt = {16'h0000, dest_r};
                `DCU_OFS_STATUS: rd_nxt = {27'h0000000, result_bit, less_flag,
                                           equal_flag, greater_flag, busy};
                default:         rd_nxt = 32'h0000_0000;
            endcase
        end
    end

    // Bus handshake; always zero wait and OKAY
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
            wr_pend_r <= 1'b0;
            wr_addr_r <= 12'h000;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend_r <= take && hwrite;
            if (take)
                wr_addr_r <= haddr[11:0];
            if (take && !hwrite)
                hrdata <= rd_nxt;
        end
    end

    // ************************************************************
    // Element addressing for the current repeat cycle
    // ************************************************************

    wire [15:0] step_w  = {9'h000, idx_r};
    wire [15:0] step_b  = {5'h00, idx_r, 4'h0};
    wire [15:0] a1_word = src1_r + (s1_rep ? step_w : 16'h0000);
    wire [15:0] a2_word = src2_r + (s2_rep ? step_w : 16'h0000);
    wire [15:0] a1_bit  = src1_r + (s1_rep ? step_b : 16'h0000);
    wire [15:0] a2_bit  = src2_r + (s2_rep ? step_b : 16'h0000);
    wire [15:0] d_addr  = dest_r + (d_rep ? step_w : 16'h0000);

    // Operand fetch: word area holds the timer or counter current value
    reg [15:0] op1;
    reg [15:0] op2;
    always @*
    begin
        case (s1_kind)
            `DCU_SRC_WORD: op1 = wmem_r[a1_word[WMEM_AW-1:0]];
            `DCU_SRC_BIT:  op1 = gather(bmem_r, a1_bit[BMEM_AW-1:0]);
            `DCU_SRC_CONST: op1 = src1_r;
            default:       op1 = 16'h0000;
        endcase
        case (s2_kind)
            `DCU_SRC_WORD: op2 = wmem_r[a2_word[WMEM_AW-1:0]];
            `DCU_SRC_BIT:  op2 = gather(bmem_r, a2_bit[BMEM_AW-1:0]);
            `DCU_SRC_CONST: op2 = src2_r;
            default:       op2 = 16'h0000;
        endcase
    end

    wire rel     = rel_eval(op, is_int, op1, op2);
    wire last    = (idx_r + 7'h01 >= rep_r);
    wire acc_now = acc_r & rel;
    // Per-element write when destination repeats, else one ANDed write at the end
    wire d_write = (state_r == ST_RUN) && (d_rep || last);
    wire d_value = d_rep ? rel : acc_now;

    // Unsigned compare of raw sign-adjusted operands for the flag triple
    wire [15:0] f1 = sign_adj(is_int, op1);
    wire [15:0] f2 = sign_adj(is_int, op2);

    // ************************************************************
    // Bus writes to registers and memories
    // ************************************************************

    wire go_wr = wr_pend_r && (wr_addr_r == `DCU_OFS_EXEC) && (state_r == ST_IDLE);
    wire go    = go_wr && hwdata[`DCU_EXEC_GO] && hwdata[`DCU_EXEC_INPUT];

    // Config writes while running are ignored so an issue never changes mid-way
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_r <= `DCU_CTRL_RESET;
            rep_r  <= `DCU_REP_RESET;
            src1_r <= 16'h0000;
            src2_r <= 16'h0000;
            dest_r <= 16'h0000;
        end
        else if (wr_pend_r && state_r == ST_IDLE)
        begin
            case (wr_addr_r)
                `DCU_OFS_CTRL:   ctrl_r <= hwdata[`DCU_CTRL_W-1:0];
                `DCU_OFS_REPEAT: rep_r  <= (hwdata[6:0] == 7'h00) ? `DCU_REP_RESET
                                                                   : hwdata[6:0];
                `DCU_OFS_SRC1:   src1_r <= hwdata[15:0];
                `DCU_OFS_SRC2:   src2_r <= hwdata[15:0];
                `DCU_OFS_DEST:   dest_r <= hwdata[15:0];
                default:         ;
            endcase
        end
    end

    // Word area written from the bus only
    always @(posedge mclk)
    begin
        if (wr_pend_r && wr_addr_r[11:8] == `DCU_WIN_WORD)
            wmem_r[wr_addr_r[WMEM_AW+1:2]] <= hwdata[15:0];
    end

    // Bit area: bus writes a 16-bit group, engine writes the result bit
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
            bmem_r <= {BMEM_N{1'b0}};
        else
        begin
            if (wr_pend_r && wr_addr_r[11:8] == `DCU_WIN_BIT && wr_addr_r[7:2] < BWORDS)
                bmem_r[wr_addr_r[7:2]*`DCU_BITS_PER_WORD +: 16] <= hwdata[15:0];
            // Engine write lands after the bus write so the result wins
            if (d_write)
                bmem_r[d_addr[BMEM_AW-1:0]] <= d_value;
        end
    end

    // ************************************************************
    // Repeat engine
    // ************************************************************

    // One element per clock; input off issues nothing at all
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state_r      <= ST_IDLE;
            idx_r        <= 7'h00;
            acc_r        <= 1'b1;
            busy         <= 1'b0;
            result_bit   <= 1'b0;
            greater_flag <= 1'b0;
            equal_flag   <= 1'b0;
            less_flag    <= 1'b0;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                begin
                    idx_r <= 7'h00;
                    acc_r <= 1'b1;
                    // Each issue with input on evaluates again
                    if (go)
                    begin
                        state_r <= ST_RUN;
                        busy    <= 1'b1;
                    end
                end
                ST_RUN:
                begin
                    acc_r <= acc_now;
                    idx_r <= idx_r + 7'h01;
                    if (d_write)
                        result_bit <= d_value;
                    if (last)
                    begin
                        state_r <= ST_IDLE;
                        busy    <= 1'b0;
                        // Flags follow only the final cycle of an equal compare
                        if (op == `DCU_OP_EQ)
                        begin
                            greater_flag <= (f1 >  f2);
                            equal_flag   <= (f1 == f2);
                            less_flag    <= (f1 <  f2);
                        end
                    end
                end
                default:
                begin
                    state_r <= ST_IDLE;
                    busy    <= 1'b0;
                end
            endcase
        end
    end

endmodule // dcu_compare_unit

//--- core/dcu_defines.vh
// Function
// - Equal compare sets the destination bit on match, clears it otherwise
// - Unequal compare sets the destination bit on mismatch, clears it on match
// - Less compare sets the bit only when first is strictly below second
// - Greater compare sets the bit only when first strictly exceeds second
// - Less-or-equal compare sets the bit when first is at most second
// - Greater-or-equal compare sets the bit when first is at least second
// - Every compare works on 16-bit values, typed word or integer
// - A bit-area source gathers 16 consecutive bits into one value
// - Repeated bit-area source advances its bit address by sixteen each cycle
// - A word source takes one word and repeat steps to the next word
// - Timer or counter source supplies its current value
// - Result takes one bit; repeated destination writes consecutive bits
// - After equal compare exactly one of greater, equal, less is on
// - Only the equal compare updates the three shared flags
// - With repeat the flags show only the final cycle's compare
// - Flags hold the most recent flag-updating compare's outcome
// - Only first source repeated: compare each against second, AND results
// - Both sources repeated, destination single: AND all pair results
// - Sources and destination repeated: each pair result to its own bit
// - Input off: no evaluation, destination keeps its last value
// - Compare evaluates again on every issue while input stays on
`ifndef DCU_DEFINES_VH
`define DCU_DEFINES_VH

// Register byte offsets
`define DCU_OFS_CTRL      12'h000
`define DCU_OFS_REPEAT    12'h004
`define DCU_OFS_SRC1      12'h008
`define DCU_OFS_SRC2      12'h00C
`define DCU_OFS_DEST      12'h010
`define DCU_OFS_EXEC      12'h014
`define DCU_OFS_STATUS    12'h018
// Operand memory windows
`define DCU_WIN_WORD      4'h1
`define DCU_WIN_BIT       4'h2

// Control field positions
`define DCU_CTRL_OP_LSB   0
`define DCU_CTRL_INT      3
`define DCU_CTRL_S1_REP   4
`define DCU_CTRL_S2_REP   5
`define DCU_CTRL_D_REP    6
`define DCU_CTRL_S1_LSB   7
`define DCU_CTRL_S2_LSB   9
`define DCU_CTRL_RESET    11'h000
`define DCU_CTRL_W        11

// Source kinds
`define DCU_SRC_WORD      2'h0
`define DCU_SRC_BIT       2'h1
`define DCU_SRC_CONST     2'h2

// Compare opcodes
`define DCU_OP_EQ         3'h0
`define DCU_OP_NE         3'h1
`define DCU_OP_LT         3'h2
`define DCU_OP_GT         3'h3
`define DCU_OP_LE         3'h4
`define DCU_OP_GE         3'h5

// Exec bits, repeat reset value, bits per word
`define DCU_EXEC_GO       0
`define DCU_EXEC_INPUT    1
`define DCU_REP_RESET     7'h01
`define DCU_BITS_PER_WORD 16

`endif

//--- testbench/data_comparison_unit_tb.sv
`include "dcu_defines.vh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end

module data_comparison_unit_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk = 1'b0;
    logic        rst  = 1'b1;
    wire         hsel, hwrite, hready, hreadyout, hresp, busy;
    wire         result_bit, greater_flag, equal_flag, less_flag;
    wire  [31:0] haddr, hwdata, hrdata;
    wire  [1:0]  htrans;
    wire  [2:0]  hsize;
    int          failures   = 0;
    int          num_checks = 0;
    int          cyc        = 0;
    logic [31:0] q;
    logic [2:0]  fl = 3'b000;

    always #10 mclk = ~mclk;
    assign hready = hreadyout;

    dcu_compare_unit DUT (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hreadyout, .hresp, .hrdata, .result_bit, .greater_flag, .equal_flag,
        .less_flag, .busy);
    dcu_scan_engine eng (.mclk, .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata);

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        eng.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [11:0] a);
        eng.xfer(1'b0, a, 32'h0000_0000, q);
    endtask
    // Expected flags as {less, equal, greater}
    function automatic logic [2:0] flg(input logic sg, input logic [15:0] a,
                                       input logic [15:0] b);
        if (a == b)
            return 3'b010;
        return (sg ? $signed(a) < $signed(b) : a < b) ? 3'b100 : 3'b001;
    endfunction
    function automatic logic rel(input logic [2:0] op, input logic sg,
                                 input logic [15:0] a, input logic [15:0] b);
        logic [2:0] f;
        f = flg(sg, a, b);
        case (op)
            `DCU_OP_EQ: return f[1];
            `DCU_OP_NE: return !f[1];
            `DCU_OP_LT: return f[2];
            `DCU_OP_GT: return f[0];
            `DCU_OP_LE: return !f[0];
            default:    return !f[2];
        endcase
    endfunction
    // Full issue; with gap at 0 the first status read already shows busy, and status is read at least twice
    task automatic run(input logic [10:0] c, input logic [6:0] n, input logic [15:0] s1,
                       input logic [15:0] s2, input logic [15:0] d);
        int k;
        wr(`DCU_OFS_CTRL, {21'h000000, c});
        wr(`DCU_OFS_REPEAT, {25'h0000000, n});
        wr(`DCU_OFS_SRC1, {16'h0000, s1});
        wr(`DCU_OFS_SRC2, {16'h0000, s2});
        wr(`DCU_OFS_DEST, {16'h0000, d});
        wr(`DCU_OFS_EXEC, 32'h0000_0003);
        k = 0;
        do
        begin
            rd(`DCU_OFS_STATUS);
            k++;
        end
        while ((q[0] !== 1'b0 || k < 2) && k < 200);
        `CHK("busy", 1'b0, q[0])
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset;
        rd(`DCU_OFS_STATUS);
        `CHK("status", 32'h0000_0000, q)
        rd(`DCU_OFS_REPEAT);
        `CHK("repeat", 32'h0000_0001, q)
        wr(12'h0FC, 32'h0000_5A5A);
        rd(12'h0FC);
        `CHK("unmapped", 32'h0000_0000, q)
    endtask
    task automatic t_ops;
        logic [15:0] a [3] = '{16'h0005, 16'h0003, 16'hFFFF};
        logic [15:0] b [3] = '{16'h0005, 16'h0009, 16'h0001};
        for (int s = 0; s < 2; s++)
            for (int o = 0; o < 6; o++)
                for (int i = 0; i < 3; i++)
                begin
                    run({2'h2, 2'h2, 3'h0, s[0], o[2:0]}, 7'h01, a[i], b[i], 16'h0000);
                    if (o == 0)
                        fl = flg(s[0], a[i], b[i]);
                    `CHK("result", rel(o[2:0], s[0], a[i], b[i]), q[4])
                    `CHK("flags", fl, q[3:1])
                end
    endtask
    task automatic t_repeat;
        logic [15:0] wv [8] = '{16'h000A, 16'h0014, 16'h001E, 16'h0028,
                                16'h000A, 16'h0019, 16'h001E, 16'h0023};
        for (int i = 0; i < 8; i++)
            wr(12'h100 + 12'(4 * i), {16'h0000, wv[i]});
        wr(12'h20C, 32'h0000_1234);
        wr(12'h210, 32'h0000_8000);
        run({2'h2, 2'h0, 3'b001, 1'b0, `DCU_OP_GE}, 7'h04, 16'h0000, 16'h000A, 16'h0000);
        `CHK("rep one src", 1'b1, q[4])
        run({2'h2, 2'h0, 3'b001, 1'b0, `DCU_OP_GE}, 7'h04, 16'h0000, 16'h000B, 16'h0000);
        `CHK("rep one src", 1'b0, q[4])
        run({2'h0, 2'h0, 3'b011, 1'b0, `DCU_OP_LE}, 7'h03, 16'h0000, 16'h0004, 16'h0000);
        `CHK("rep two src", 1'b1, q[4])
        run({2'h0, 2'h0, 3'b011, 1'b0, `DCU_OP_EQ}, 7'h02, 16'h0000, 16'h0004, 16'h0000);
        `CHK("rep and", 1'b0, q[4])
        `CHK("last flags", 3'b100, q[3:1])
        run({2'h0, 2'h0, 3'b111, 1'b0, `DCU_OP_EQ}, 7'h03, 16'h0000, 16'h0004, 16'h0010);
        `CHK("last flags", 3'b010, q[3:1])
        rd(12'h204);
        `CHK("dest bits", 32'h0000_0005, q)
        run({2'h2, 2'h1, 3'b001, 1'b0, `DCU_OP_GT}, 7'h02, 16'h0030, 16'h1000, 16'h0000);
        `CHK("bit src", 1'b1, q[4])
        run({2'h2, 2'h1, 3'b001, 1'b1, `DCU_OP_GT}, 7'h02, 16'h0030, 16'h1000, 16'h0000);
        `CHK("bit src int", 1'b0, q[4])
        rd(12'h200);
        `CHK("dest bit", 1'b0, q[0])
    endtask
    task automatic t_hold;
        eng.gap = 2;
        run({2'h2, 2'h2, 3'h0, 1'b0, `DCU_OP_EQ}, 7'h01, 16'h0007, 16'h0007, 16'h0000);
        wr(`DCU_OFS_SRC2, 32'h0000_0008);
        wr(`DCU_OFS_EXEC, 32'h0000_0001);
        rd(`DCU_OFS_STATUS);
        rd(`DCU_OFS_STATUS);
        `CHK("held result", 1'b1, q[4])
        `CHK("held flags", 3'b010, q[3:1])
        run({2'h2, 2'h2, 3'h0, 1'b0, `DCU_OP_EQ}, 7'h01, 16'h0007, 16'h0008, 16'h0000);
        `CHK("again result", 1'b0, q[4])
        `CHK("again flags", 3'b100, q[3:1])
        run({2'h2, 2'h2, 3'h0, 1'b0, 3'h6}, 7'h01, 16'h0007, 16'h0007, 16'h0000);
        `CHK("bad op result", 1'b0, q[4])
        `CHK("bad op flags", 3'b100, q[3:1])
        eng.gap = 0;
    endtask

    task end_sim;
        if (failures == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Hang guard, far above the fewer than one thousand cycles the run needs
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            end_sim;
        end
    end

    // Main sequence, with a second reset in mid-run
    initial
    begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        t_reset;
        t_ops;
        t_repeat;
        t_hold;
        rst <= 1'b1;
        @(posedge mclk);
        rst <= 1'b0;
        t_reset;
        end_sim;
    end
endmodule // data_comparison_unit_tb

bind dcu_compare_unit dcu_checker u_chk (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .result_bit, .greater_flag,
    .equal_flag, .less_flag, .busy);

//--- testbench/dcu_checker.sv
`include "dcu_defines.vh"

module dcu_checker (
    input wire        mclk,
    input wire        rst,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [2:0]  hsize,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire        hreadyout,
    input wire        hresp,
    input wire [31:0] hrdata,
    input wire        result_bit,
    input wire        greater_flag,
    input wire        equal_flag,
    input wire        less_flag,
    input wire        busy
);
    timeunit 1ns;
    timeprecision 1ns;
    logic        wv_r;
    logic [11:0] wa_r;
    logic [2:0]  op_r;
    logic [6:0]  rep_r;
    logic [6:0]  cnt_r;
    wire  [2:0]  flags = {greater_flag, equal_flag, less_flag};

    // Shadow of opcode and repeat; writes while busy are dropped by the unit too
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            wv_r  <= 1'b0;
            wa_r  <= 12'h000;
            op_r  <= 3'h0;
            rep_r <= 7'h01;
            cnt_r <= 7'h00;
        end
        else
        begin
            wv_r  <= hsel & htrans[1] & hready & hwrite;
            wa_r  <= haddr[11:0];
            cnt_r <= busy ? cnt_r + 7'h01 : 7'h00;
            if (wv_r && !busy && wa_r == `DCU_OFS_CTRL)
                op_r <= hwdata[2:0];
            if (wv_r && !busy && wa_r == `DCU_OFS_REPEAT)
                rep_r <= (hwdata[6:0] == 7'h00) ? 7'h01 : hwdata[6:0];
        end
    end

    // ************************************************************
    // Properties
    // ************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence idle_two;
        !busy ##1 !busy;
    endsequence
    sequence exec_go;
        wv_r && wa_r == `DCU_OFS_EXEC && hwdata[1:0] == 2'h3 && !busy;
    endsequence

    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus answer not zero-wait OKAY");
    flags_onehot_a: assert property ($onehot0(flags))
        else $error("more than one relation flag on");
    flags_kept_a: assert property (|flags |=> $onehot(flags))
        else $error("relation flags lost after being set");
    result_hold_a: assert property (idle_two |-> $stable(result_bit))
        else $error("result moved while idle");
    flag_hold_a: assert property (idle_two |-> $stable(flags))
        else $error("flags moved while idle");
    flag_owner_a: assert property (busy && op_r != `DCU_OP_EQ |=> $stable(flags))
        else $error("flags moved by a non-equal compare");
    exec_start_a: assert property (exec_go |=> busy)
        else $error("issue with input on did not start");
    exec_off_a: assert property (wv_r && wa_r == `DCU_OFS_EXEC && !hwdata[1] && !busy
        |=> !busy) else $error("issue with input off started");
    busy_len_a: assert property ($fell(busy) |-> cnt_r == rep_r)
        else $error("busy length differs from repeat count");
    eq_single_a: assert property ($fell(busy) && op_r == `DCU_OP_EQ && rep_r == 7'h01
        |-> result_bit == equal_flag) else $error("equal result and flag disagree");
endmodule // dcu_checker

//--- testbench/dcu_scan_engine.sv
module dcu_scan_engine (
    input  wire         mclk,
    input  wire         hready,
    input  wire  [31:0] hrdata,
    output logic        hsel,
    output logic [31:0] haddr,
    output logic [1:0]  htrans,
    output logic        hwrite,
    output logic [2:0]  hsize,
    output logic [31:0] hwdata
);
    timeunit 1ns;
    timeprecision 1ns;
    int gap = 0;

    // Idle bus at time zero
    initial
    begin
        hsel   = 1'b0;
        haddr  = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0000_0000;
    end

    // One single word transfer, entered just after a rising edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {20'h00000, a};
        hwrite <= w;
        do @(posedge mclk); while (hready !== 1'b1);
        // Released lines flip so a stale value never looks valid
        hsel   <= 1'b0;
        htrans <= 2'h0;
        haddr  <= ~haddr;
        hwdata <= w ? d : ~hwdata;
        do @(posedge mclk); while (hready !== 1'b1);
        q = hrdata;
        hwdata <= ~hwdata;
        repeat (gap) @(posedge mclk);
    endtask
endmodule // dcu_scan_engine
